// [verilog/prdm_pkg.sv]
package prdm_pkg;
    // number of i/o lines handled by the mux
    localparam int unsigned NUM_LINES = 8;
    localparam int unsigned SEL_W = 3;
    // line positions
    localparam int unsigned LINE_TCK = 0;
    localparam int unsigned LINE_TMS = 1;
    localparam int unsigned LINE_TDO = 2;
    localparam int unsigned LINE_TDI = 3;
    localparam int unsigned LINE_CLKOUT = 4;
    // peripheral function codes, a..h
    localparam logic [2:0] FUNC_A = 3'h0;
    localparam logic [2:0] FUNC_F = 3'h5;
    localparam logic [2:0] FUNC_H = 3'h7;
    // reset values
    localparam logic [7:0] PULLUP_RST = 8'h01;
    localparam logic [7:0] PERIPH_EN_RST = 8'h10;
    localparam logic FRC_RST = 1'b1;
endpackage : prdm_pkg

// [verilog/prdm_line.sv]
`timescale 1ns/1ps
// one i/o line: peripheral priority pick and pad drive decision
module prdm_line (
    input wire logic [7:0] func_en,
    input wire logic [7:0] func_out,
    input wire logic [7:0] func_oe,
    input wire logic periph_en,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    output logic pad_o,
    output logic pad_oe,
    output logic [2:0] active_func
);
    logic [2:0] pick;
    logic any_en;

    // the highest-letter enabled function wins
    always_comb begin
        pick = prdm_pkg::FUNC_A;
        for (int i = 0; i < 8; i++) begin
            if (func_en[i]) begin
                pick = i[2:0];
            end
        end
    end

    assign any_en = |func_en;
    assign active_func = pick;
    assign pad_o = (periph_en && any_en) ? func_out[pick] : gpio_out;
    assign pad_oe = (periph_en && any_en) ? func_oe[pick] : gpio_oe;
endmodule : prdm_line

// [verilog/prdm_top.sv]
`timescale 1ns/1ps
module prdm_top (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] pad_i,
    input wire logic slow_rc_oscillator,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    input wire logic [7:0] periph_en,
    input wire logic [7:0] pullup_en,
    input wire logic pullup_we,
    input wire logic [23:0] func_sel,
    input wire logic [7:0] func_en_all,
    input wire logic [63:0] func_out,
    input wire logic [63:0] func_oe,
    input wire logic force_slow_clock_out,
    input wire logic force_we,
    input wire logic [7:0] periph_en_we,
    input wire logic dbg_two_pin_mode,
    input wire logic debug_wire_second_data,
    input wire logic tdo_out,
    output logic [7:0] pad_o,
    output logic [7:0] pad_oe,
    output logic [7:0] pad_pu,
    output logic [7:0] adc_in_en,
    output logic [7:0] pad_in_sync,
    output logic test_port_en,
    output logic startup_slow_clock_out
);
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic rst_d1_q;
    logic tp_en_q;
    logic [7:0] pu_q;
    logic [7:0] pen_q;
    logic frc_q;
    logic [7:0] pad_o_q;
    logic [7:0] pad_oe_q;
    logic [7:0] pad_pu_q;
    logic [7:0] adc_q;
    logic [7:0] mux_o;
    logic [7:0] mux_oe;
    logic [23:0] act_func;
    logic [7:0] drv_o;
    logic [7:0] drv_oe;
    logic [7:0] pu_d;
    logic release_w;
    logic clkout_on;

    // pins cross two flops before any logic reads them
    always_ff @(posedge core_clk) begin
        sync1_q <= pad_i;
        sync2_q <= sync1_q;
    end

    // release seen as first cycle with rstn high after a low cycle
    always_ff @(posedge core_clk) begin
        rst_d1_q <= rstn;
    end
    assign release_w = rstn && !rst_d1_q;

    // strap caught by a clocked process at release, held till next reset
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tp_en_q <= 1'b0;
        end else if (release_w) begin
            tp_en_q <= !sync2_q[prdm_pkg::LINE_TCK];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pu_q <= prdm_pkg::PULLUP_RST;
            pen_q <= prdm_pkg::PERIPH_EN_RST;
            frc_q <= prdm_pkg::FRC_RST;
        end else begin
            if (pullup_we) begin
                pu_q <= pullup_en;
            end
            for (int i = 0; i < 8; i++) begin
                if (periph_en_we[i]) begin
                    pen_q[i] <= periph_en[i];
                end
            end
            if (force_we) begin
                frc_q <= force_slow_clock_out;
            end
        end
    end

    // function enables decoded from per-line 3-bit selection
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_line
            logic [7:0] en_vec;
            assign en_vec = func_en_all[g] ? (8'h01 << func_sel[g*3 +: 3]) : 8'h00;
            prdm_line u_line (
                .func_en(en_vec),
                .func_out(func_out[g*8 +: 8]),
                .func_oe(func_oe[g*8 +: 8]),
                .periph_en(pen_q[g]),
                .gpio_out(gpio_out[g]),
                .gpio_oe(gpio_oe[g]),
                .pad_o(mux_o[g]),
                .pad_oe(mux_oe[g]),
                .active_func(act_func[g*3 +: 3])
            );
        end
    endgenerate

    // f stays default while the line's select is unwritten at f
    assign clkout_on = frc_q && pen_q[prdm_pkg::LINE_CLKOUT]
        && (!func_en_all[prdm_pkg::LINE_CLKOUT]
        || act_func[prdm_pkg::LINE_CLKOUT*3 +: 3] == prdm_pkg::FUNC_F);

    always_comb begin
        drv_o = mux_o;
        drv_oe = mux_oe;
        pu_d = pu_q;
        if (clkout_on) begin
            drv_o[prdm_pkg::LINE_CLKOUT] = 1'b0;
            drv_oe[prdm_pkg::LINE_CLKOUT] = 1'b1;
        end
        if (dbg_two_pin_mode) begin
            drv_o[prdm_pkg::LINE_TCK] = debug_wire_second_data;
            drv_oe[prdm_pkg::LINE_TCK] = 1'b1;
        end
        if (tp_en_q) begin
            drv_oe[prdm_pkg::LINE_TCK] = 1'b0;
            drv_oe[prdm_pkg::LINE_TMS] = 1'b0;
            drv_oe[prdm_pkg::LINE_TDI] = 1'b0;
            drv_o[prdm_pkg::LINE_TCK] = 1'b0;
            drv_o[prdm_pkg::LINE_TMS] = 1'b0;
            drv_o[prdm_pkg::LINE_TDI] = 1'b0;
            drv_o[prdm_pkg::LINE_TDO] = tdo_out;
            drv_oe[prdm_pkg::LINE_TDO] = 1'b1;
            pu_d[prdm_pkg::LINE_TCK] = 1'b1;
            pu_d[prdm_pkg::LINE_TMS] = 1'b1;
            pu_d[prdm_pkg::LINE_TDI] = 1'b1;
            pu_d[prdm_pkg::LINE_TDO] = 1'b0;
        end
        if (!rstn) begin
            drv_oe = 8'h00;
            drv_o = 8'h00;
            pu_d = prdm_pkg::PULLUP_RST;
        end
    end

    always_ff @(posedge core_clk) begin
        pad_o_q <= drv_o;
        pad_oe_q <= drv_oe;
        pad_pu_q <= pu_d;
        adc_q <= ~drv_oe;
    end

    assign pad_o = pad_o_q;
    assign pad_oe = pad_oe_q;
    assign pad_pu = pad_pu_q;
    assign adc_in_en = adc_q;
    assign pad_in_sync = sync2_q;
    assign test_port_en = tp_en_q;

    // the rc clock is thousands of core_clk periods long, so syncing it and
    // driving it from a flop costs only a few ns of jitter
    logic clk_en_q;
    logic rc_s1_q;
    logic rc_s2_q;
    logic rc_out_q;
    logic rc_gate_w;
    always_ff @(posedge core_clk) begin
        rc_s1_q <= slow_rc_oscillator;
        rc_s2_q <= rc_s1_q;
    end
    // reset keeps the clock enabled, so it runs from power-up
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            clk_en_q <= 1'b1;
        end else begin
            clk_en_q <= clkout_on;
        end
    end
    assign rc_gate_w = rc_s2_q && clk_en_q;
    always_ff @(posedge core_clk) begin
        rc_out_q <= rc_gate_w;
    end
    assign startup_slow_clock_out = rc_out_q;

    // assertions
    a_strap_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(rstn) && !$past(release_w) |-> $stable(tp_en_q))
        else $error("test port enable changed outside release");
    a_release_once: assert property (@(posedge core_clk)
        release_w |=> !release_w)
        else $error("release seen twice");
    a_strap_sample: assert property (@(posedge core_clk)
        rstn && !rst_d1_q |=> tp_en_q == !$past(sync2_q[0]))
        else $error("test port strap not sampled");
    a_reset_tp_off: assert property (@(posedge core_clk)
        !rstn |=> !test_port_en)
        else $error("test port on during reset");
    a_tck_pu_reset: assert property (@(posedge core_clk)
        !rstn |=> pad_pu[0])
        else $error("test clock pull-up off during reset");
    a_reset_pu: assert property (@(posedge core_clk)
        !rstn |=> pad_pu == prdm_pkg::PULLUP_RST)
        else $error("reset pull-ups wrong");
    a_tp_pullups: assert property (@(posedge core_clk) disable iff (!rstn)
        tp_en_q && $past(tp_en_q) && $past(rstn) |-> pad_pu[3:0] == 4'hb)
        else $error("test port pull-ups wrong");
    a_tp_owns: assert property (@(posedge core_clk) disable iff (!rstn)
        tp_en_q && $past(tp_en_q) && $past(rstn) |-> pad_oe[3:0] == 4'h4)
        else $error("test port does not own pins");
    a_tdo_drive: assert property (@(posedge core_clk) disable iff (!rstn)
        tp_en_q && $past(tp_en_q) && $past(rstn) |-> pad_o[2] == $past(tdo_out))
        else $error("test data out not driven");
    a_tp_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
        tp_en_q && $past(tp_en_q) && $past(rstn) |-> (pad_o & 8'h0b) == 8'h00)
        else $error("test input lines carry mux data");
    a_reset_inputs: assert property (@(posedge core_clk)
        !rstn |=> pad_oe == 8'h00)
        else $error("pins driven during reset");
    a_reset_levels: assert property (@(posedge core_clk)
        !rstn |=> pad_o == 8'h00)
        else $error("pin levels set during reset");
    a_reset_adc: assert property (@(posedge core_clk)
        !rstn |=> adc_in_en == 8'hff)
        else $error("analog path closed during reset");
    a_pen_reset: assert property (@(posedge core_clk)
        !rstn |=> pen_q == prdm_pkg::PERIPH_EN_RST)
        else $error("peripheral enables wrong after reset");
    a_frc_reset: assert property (@(posedge core_clk)
        !rstn |=> frc_q)
        else $error("force bit clear after reset");
    a_reset_clk_on: assert property (@(posedge core_clk)
        !rstn |=> clk_en_q)
        else $error("startup clock off during reset");
    a_clk_stop: assert property (@(posedge core_clk) disable iff (!rstn)
        force_we && !force_slow_clock_out |=> ##1 !clk_en_q)
        else $error("startup clock not stopped");
    a_clk_en_follow: assert property (@(posedge core_clk)
        $past(rstn) |-> clk_en_q == $past(clkout_on))
        else $error("clock enable does not follow conditions");
    a_clkout_other: assert property (@(posedge core_clk)
        func_en_all[prdm_pkg::LINE_CLKOUT]
        && act_func[prdm_pkg::LINE_CLKOUT*3 +: 3] != prdm_pkg::FUNC_F |-> !clkout_on)
        else $error("startup clock kept on another function");
    a_clkout_oe: assert property (@(posedge core_clk)
        $past(rstn) && $past(clkout_on) |-> pad_oe[4] && !pad_o[4])
        else $error("clock-out line not driven");
    a_clkout_gate: assert property (@(posedge core_clk)
        !clk_en_q |=> !startup_slow_clock_out)
        else $error("startup clock leaks while disabled");
    a_clkout_pass: assert property (@(posedge core_clk)
        clk_en_q && rc_s2_q |=> startup_slow_clock_out)
        else $error("startup clock not passed");
    a_adc_block: assert property (@(posedge core_clk)
        pad_oe[4] |-> !adc_in_en[4])
        else $error("analog path open while driving");
    a_adc_open: assert property (@(posedge core_clk)
        $past(rstn) |-> adc_in_en == ~pad_oe)
        else $error("analog path does not follow drivers");
    a_pu_indep: assert property (@(posedge core_clk) disable iff (!rstn)
        pullup_we && !tp_en_q |=> ##1 pad_pu[7:4] == $past(pullup_en[7:4], 2))
        else $error("pull-up not per line");
    a_pu_follow: assert property (@(posedge core_clk)
        $past(rstn) && !$past(tp_en_q) |-> pad_pu == $past(pu_q))
        else $error("pull-ups do not follow their enables");
    a_two_pin: assert property (@(posedge core_clk)
        $past(rstn) && $past(dbg_two_pin_mode) && !$past(tp_en_q)
        |-> pad_oe[0] && pad_o[0] == $past(debug_wire_second_data))
        else $error("second debug data not on line");
    a_line0_gpio: assert property (@(posedge core_clk)
        $past(rstn) && !$past(dbg_two_pin_mode) && !$past(tp_en_q) && !$past(pen_q[0])
        |-> pad_oe[0] == $past(gpio_oe[0]))
        else $error("line 0 not released to gpio");
    a_gpio_path: assert property (@(posedge core_clk)
        $past(rstn) && !$past(tp_en_q) && !$past(pen_q[1])
        |-> pad_o[1] == $past(gpio_out[1]) && pad_oe[1] == $past(gpio_oe[1]))
        else $error("line 1 not released to gpio");
    a_gpio_upper: assert property (@(posedge core_clk)
        $past(rstn) && $past(pen_q[7:5]) == 3'h0 |-> pad_oe[7:5] == $past(gpio_oe[7:5]))
        else $error("upper lines not released to gpio");
    a_func_code: assert property (@(posedge core_clk)
        func_en_all[1] |-> act_func[5:3] == func_sel[5:3])
        else $error("selected function code not applied");
    a_pin_sync: assert property (@(posedge core_clk)
        $past(rstn, 2) |-> pad_in_sync == $past(pad_i, 2))
        else $error("pin read back not two flops late");
    c_tp_on: cover property (@(posedge core_clk) release_w ##1 tp_en_q);
    c_tp_off: cover property (@(posedge core_clk) release_w ##1 !tp_en_q);
    c_clk_stop: cover property (@(posedge core_clk) clk_en_q ##1 !clk_en_q);
    c_two_pin: cover property (@(posedge core_clk) dbg_two_pin_mode && !tp_en_q);
    c_f_selected: cover property (@(posedge core_clk) func_en_all[4] && clkout_on);
endmodule : prdm_top

// [test/prdm_board.sv]
`timescale 1ns/1ps
// board side of the pins: debug probe strap on line 0, pull-ups, floating lines
module prdm_board (
    input wire logic core_clk,
    input wire logic [7:0] pad_o,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pu,
    input wire logic strap_low,
    output logic [7:0] pad_i
);
    logic [7:0] float_q = 8'h00;
    // an undriven, unpulled line wanders so a stale value never looks valid
    always @(posedge core_clk) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe[i]) pad_i[i] = pad_o[i];
            else if (i == 0 && strap_low) pad_i[i] = 1'b0;
            else if (pad_pu[i]) pad_i[i] = 1'b1;
            else pad_i[i] = float_q[i];
        end
    end
endmodule : prdm_board

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
    logic core_clk = 0, rstn = 0, slow_rc_oscillator = 0, pullup_we = 0, force_we = 0;
    logic force_slow_clock_out = 1, dbg_two_pin_mode = 0, debug_wire_second_data = 0;
    logic tdo_out = 0, strap_low = 0, test_port_en, startup_slow_clock_out;
    logic [7:0] gpio_out = 0, gpio_oe = 0, periph_en = 0, pullup_en = 0, func_en_all = 0;
    logic [7:0] periph_en_we = 0, pad_i, pad_o, pad_oe, pad_pu, adc_in_en, pad_in_sync;
    logic [23:0] func_sel = 0;
    logic [63:0] func_out = 0, func_oe = 0;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    prdm_top uut (.core_clk(core_clk), .rstn(rstn), .pad_i(pad_i),
        .slow_rc_oscillator(slow_rc_oscillator), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .periph_en(periph_en), .pullup_en(pullup_en), .pullup_we(pullup_we),
        .func_sel(func_sel), .func_en_all(func_en_all), .func_out(func_out),
        .func_oe(func_oe), .force_slow_clock_out(force_slow_clock_out), .force_we(force_we),
        .periph_en_we(periph_en_we), .dbg_two_pin_mode(dbg_two_pin_mode),
        .debug_wire_second_data(debug_wire_second_data), .tdo_out(tdo_out), .pad_o(pad_o),
        .pad_oe(pad_oe), .pad_pu(pad_pu), .adc_in_en(adc_in_en), .pad_in_sync(pad_in_sync),
        .test_port_en(test_port_en), .startup_slow_clock_out(startup_slow_clock_out));
    prdm_board board (.core_clk(core_clk), .pad_o(pad_o), .pad_oe(pad_oe), .pad_pu(pad_pu),
        .strap_low(strap_low), .pad_i(pad_i));
    initial forever #2 core_clk = ~core_clk;
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    // cut a hang short well past the roughly 150 cycles the tests need
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            complete_run();
        end
    end
    task cmp8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : cmp8
    task cmp1(input logic got, input logic exp, input string msg);
        cmp8({7'h00, got}, {7'h00, exp}, msg);
    endtask : cmp1
    // registered pads answer two edges after a write pulse; one spare edge
    task settle;
        repeat (3) @(negedge core_clk);
    endtask : settle
    task pulse(input int which);
        {pullup_we, force_we, periph_en_we} = {which == 0, which == 1, 8'hff & {8{which == 2}}};
        @(negedge core_clk);
        {pullup_we, force_we, periph_en_we} = 10'h000;
        settle();
    endtask : pulse
    // strap is steady long before release, as the probe must hold it
    task restart(input logic strap);
        strap_low = strap;
        rstn = 0;
        settle();
        cmp8(pad_pu, 8'h01, "pull-ups in reset");
        cmp8(adc_in_en, 8'hff, "adc path in reset");
        slow_rc_oscillator = 1;
        settle();
        cmp1(startup_slow_clock_out, 1'b1, "clock out in reset");
        slow_rc_oscillator = 0;
        settle();
        cmp1(startup_slow_clock_out, 1'b0, "clock out low in reset");
        rstn = 1;
        settle();
    endtask : restart
    task t_defaults;
        restart(1'b0);
        cmp1(test_port_en, 1'b0, "port off, clock pin high");
        cmp8(pad_pu, 8'h01, "pull-ups after reset");
        cmp8(pad_oe, 8'h10, "only clock-out line driven");
        slow_rc_oscillator = 1;
        settle();
        cmp1(startup_slow_clock_out, 1'b1, "function f default");
        {func_sel[14:12], func_en_all} = {prdm_pkg::FUNC_F, 8'h10};
        settle();
        cmp1(startup_slow_clock_out, 1'b1, "function f selected");
        {slow_rc_oscillator, func_sel, func_en_all} = 33'h0;
        $display("test defaults done");
    endtask : t_defaults
    task t_test_port;
        restart(1'b1);
        cmp1(test_port_en, 1'b1, "port on, clock pin low");
        cmp8(pad_pu & 8'h0f, 8'h0b, "port pull-ups");
        tdo_out = 1;
        gpio_oe = 8'h0f;
        settle();
        cmp8(pad_oe & 8'h0f, 8'h04, "port owns its pins");
        cmp1(pad_o[2], 1'b1, "data out pin");
        strap_low = 0;
        settle();
        cmp1(test_port_en, 1'b1, "decision held");
        {gpio_oe, tdo_out} = 9'h000;
        $display("test port done");
    endtask : t_test_port
    task t_gpio_pullup;
        restart(1'b0);
        {gpio_oe, gpio_out, pullup_en} = {8'h03, 8'h02, 8'h84};
        pulse(0);
        cmp8(pad_oe, 8'h13, "gpio drive");
        cmp8(pad_o & 8'h03, 8'h02, "gpio levels");
        cmp8(pad_in_sync & 8'h03, 8'h02, "pin read back");
        cmp8(pad_pu, 8'h84, "separate pull-ups");
        cmp8(adc_in_en, 8'hec, "adc blocked on driven lines");
        {gpio_oe, periph_en, func_en_all, func_oe} = {8'h00, 8'h02, 8'h02, 64'hff00};
        pulse(2);
        for (int c = 0; c < 8; c++) begin
            func_sel[5:3] = c[2:0];
            func_out[15:8] = 8'h01 << c;
            settle();
            cmp1(pad_o[1], 1'b1, "selected function drives");
        end
        $display("test gpio and mux done");
    endtask : t_gpio_pullup
    task t_clock_out;
        for (int m = 0; m < 3; m++) begin
            restart(1'b0);
            {dbg_two_pin_mode, debug_wire_second_data} = 2'b11;
            {func_sel, func_en_all, periph_en} = {24'h000000, 8'h00, 8'h10};
            force_slow_clock_out = (m != 0);
            if (m == 0) pulse(1);
            if (m == 1) func_en_all = 8'h10;
            if (m == 2) begin
                periph_en = 8'h00;
                pulse(2);
            end
            settle();
            cmp1(pad_o[0], 1'b1, "two-pin debug data");
            slow_rc_oscillator = 1;
            settle();
            cmp1(startup_slow_clock_out, 1'b0, "clock out stopped");
            {slow_rc_oscillator, force_slow_clock_out, func_en_all} = 10'h100;
        end
        dbg_two_pin_mode = 0;
        $display("test clock out done");
    endtask : t_clock_out
    initial begin
        repeat (3) @(negedge core_clk);
        t_defaults();
        t_test_port();
        t_gpio_pullup();
        t_clock_out();
        complete_run();
    end
endmodule : tb
